// >>> include/cfg_query_pkg.sv
// Purpose: Constants and types for the configuration query and snapshot block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Real values travel as 32-bit single precision bit patterns
package cfg_query_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CMD        = 8'h00;
	localparam logic [7:0] OFF_STATUS     = 8'h04;
	localparam logic [7:0] OFF_RESP0      = 8'h08;
	localparam logic [7:0] OFF_RESP4      = 8'h18;
	localparam logic [7:0] OFF_SPD_SCALE  = 8'h20;
	localparam logic [7:0] OFF_TRQ_OFFSET = 8'h24;
	localparam logic [7:0] OFF_TRQ_SCALE  = 8'h28;
	localparam logic [7:0] OFF_TRIG_LEVEL = 8'h2C;
	localparam logic [7:0] OFF_MISC       = 8'h30;
	localparam logic [7:0] OFF_CHAN       = 8'h34;
	localparam logic [7:0] OFF_WIRING     = 8'h38;
	localparam logic [7:0] OFF_VSCALE0    = 8'h40;
	localparam logic [7:0] OFF_VSCALE3    = 8'h4C;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_TIME0 = 8'h50;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_TIME2 = 8'h58;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_START0 = 8'h60;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_START2 = 8'h68;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_END0  = 8'h70;
	localparam logic [7:0] OFF_STANDBY_POWER_QUERY_END2  = 8'h78;

	// Command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_IDX_LSB = 8;

	// Status word fields
	localparam int ST_VALID_BIT = 0;
	localparam int ST_ERROR_BIT = 1;
	localparam int ST_COUNT_LSB = 4;
	localparam int ST_STR_LSB   = 8;

	// Misc word fields
	localparam int MISC_TB_LSB     = 0;
	localparam int MISC_TIN_LSB    = 8;
	localparam int MISC_TMETH_LSB  = 12;
	localparam int MISC_TPOS_LSB   = 16;
	localparam int MISC_TRQ_LSB    = 20;
	localparam int MISC_STANDBY_POWER_QUERY_LSB   = 24;

	// Channel word fields
	localparam int CHAN_GRP_LSB    = 0;
	localparam int CHAN_SCALED_LSB = 8;

	typedef enum logic [4:0] {
		OP_NONE          = 5'h00,
		OP_SPEED_SCALE   = 5'h01,
		OP_STANDBY       = 5'h02,
		OP_TIMEBASE      = 5'h03,
		OP_TRIGGER       = 5'h04,
		OP_TORQUE_SRC    = 5'h05,
		OP_TORQUE_OFFSET = 5'h06,
		OP_TORQUE_SCALE  = 5'h07,
		OP_VOLTAGE_SCALE = 5'h08,
		OP_GROUP_MEMBER  = 5'h09,
		OP_WIRING        = 5'h0A,
		OP_SNAP_STORE    = 5'h0B,
		OP_SNAP_RESTORE  = 5'h0C
	} cmd_op_t;

	// Limits of the integer codes
	localparam logic [4:0] TIMEBASE_MAX = 5'h14;
	localparam logic [1:0] TORQUE_MAX   = 2'h2;
	localparam logic [2:0] WIRING_MAX   = 3'h4;
	localparam logic [2:0] GROUP_COUNT  = 3'h3;
	localparam logic [2:0] CHAN_COUNT   = 3'h4;

	// Response constants
	localparam logic [7:0]  STR_TIME_METHOD  = 8'h41;
	localparam logic [7:0]  STR_LEVEL_METHOD = 8'h44;
	localparam logic [31:0] REAL_ZERO        = 32'h00000000;
	localparam logic [2:0]  CNT_ONE          = 3'h1;
	localparam logic [2:0]  CNT_LEVEL        = 3'h3;
	localparam logic [2:0]  CNT_TRIGGER      = 3'h4;
	localparam logic [2:0]  CNT_TIME         = 3'h5;
	localparam int          RESP_FIELDS      = 5;

	typedef struct packed {
		logic [31:0]           speedScale;
		logic [31:0]           torqueOffset;
		logic [31:0]           torqueScale;
		logic [31:0]           trigLevel;
		logic [4:0]            timebase;
		logic [2:0]            trigInput;
		logic [1:0]            trigMethod;
		logic [1:0]            trigPos;
		logic [1:0]            torqueSrc;
		logic [2:0]            stbyLevel;
		logic [3:0][1:0]       chanGroup;
		logic [3:0]            chanScaled;
		logic [2:0][2:0]       wiring;
		logic [3:0][31:0]      voltage_scale_query;
		logic [2:0][3:0][7:0]  stbyTime;
		logic [2:0][31:0]      stbyStart;
		logic [2:0][31:0]      stbyEnd;
	} cfg_t;

	localparam cfg_t CFG_RESET = '0;

endpackage

// >>> rtl/config_query_and_temp_store.sv
// Purpose: Configuration query answers and volatile configuration snapshot
// Assumes: Classic Wishbone master, one request outstanding, full-word sel for commands
// Notes:   Ack comes one cycle after the request; write takes effect at that edge
`timescale 1ns/100ps

// Overview of operation
// - Speed scale query answers the stored scale as one real field.
// - Time-based standby answers string A then four integer minimum times.
// - Level standby answers string D, start level real, end level real.
// - Timebase query answers code 0 to 20 in 1-2-5 steps.
// - Trigger query answers input, method, position integers then level real.
// - Trigger input code 0 to 7 selects a channel voltage or current.
// - Trigger method codes 0 to 3: rising, falling, rectified, high frequency.
// - Trigger position codes 0 to 3 mean 0, 25, 50, 75 percent.
// - Fourth trigger field is the configured trigger level real.
// - Torque source answers 0 none, 1 analog, 2 digital.
// - Torque offset and scale queries answer one real field each.
// - Voltage scale query answers the factor, or 0.0 when unscaled.
// - Group membership answers group 1 to 3, or 0 when absent.
// - Wiring query answers code 0 to 4 per group.
// - Store command copies the whole configuration into the snapshot.
// - Snapshot is volatile and empty after reset.
// - Restore reloads the snapshot, or raises a command error if none.
// - One restore allowed per store.
module config_query_and_temp_store (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o
);

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic inRange(input logic [2:0] idx, input logic [2:0] top);
		return (idx != 3'h0) && (idx <= top);
	endfunction

	cfg_query_pkg::cfg_t cfg_q;
	cfg_query_pkg::cfg_t snap_q;
	logic                snapValid_q;
	logic                cmdError_q;
	logic [2:0]          respCount_q;
	logic [7:0]          respStr_q;
	logic [31:0]         respField_q [cfg_query_pkg::RESP_FIELDS];
	logic                ack_q;
	logic                ack_d;
	logic [31:0]         dat_q;
	logic [31:0]         dat_d;

	logic                access;
	logic                wrEn;
	logic                cmdFire;
	logic [4:0]          cmdOp;
	logic [2:0]          cmdIdx;
	logic [1:0]          grpSel;
	logic [1:0]          chSel;
	logic                storeFire;
	logic                restoreFire;
	logic                cmdBad;

	assign access = cyc_i && stb_i && !ack_q;
	assign ack_d  = access;
	assign wrEn   = access && we_i;
	assign cmdFire = wrEn && (adr_i == cfg_query_pkg::OFF_CMD) && (sel_i == 4'hF);
	assign cmdOp   = dat_i[cfg_query_pkg::CMD_OP_LSB +: 5];
	assign cmdIdx  = dat_i[cfg_query_pkg::CMD_IDX_LSB +: 3];
	assign grpSel  = 2'(cmdIdx - 3'h1);
	assign chSel   = 2'(cmdIdx - 3'h1);
	assign storeFire   = cmdFire && (cmdOp == cfg_query_pkg::OP_SNAP_STORE);
	assign restoreFire = cmdFire && (cmdOp == cfg_query_pkg::OP_SNAP_RESTORE);

	// Bus answer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= ack_d;
			dat_q <= ack_d ? dat_d : 32'h00000000;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// Read mux
	always_comb begin
		dat_d = 32'h00000000;
		unique case (adr_i)
			cfg_query_pkg::OFF_STATUS: begin
				dat_d[cfg_query_pkg::ST_VALID_BIT]      = snapValid_q;
				dat_d[cfg_query_pkg::ST_ERROR_BIT]      = cmdError_q;
				dat_d[cfg_query_pkg::ST_COUNT_LSB +: 3] = respCount_q;
				dat_d[cfg_query_pkg::ST_STR_LSB +: 8]   = respStr_q;
			end
			cfg_query_pkg::OFF_SPD_SCALE:  dat_d = cfg_q.speedScale;
			cfg_query_pkg::OFF_TRQ_OFFSET: dat_d = cfg_q.torqueOffset;
			cfg_query_pkg::OFF_TRQ_SCALE:  dat_d = cfg_q.torqueScale;
			cfg_query_pkg::OFF_TRIG_LEVEL: dat_d = cfg_q.trigLevel;
			cfg_query_pkg::OFF_MISC: begin
				dat_d[cfg_query_pkg::MISC_TB_LSB +: 5]    = cfg_q.timebase;
				dat_d[cfg_query_pkg::MISC_TIN_LSB +: 3]   = cfg_q.trigInput;
				dat_d[cfg_query_pkg::MISC_TMETH_LSB +: 2] = cfg_q.trigMethod;
				dat_d[cfg_query_pkg::MISC_TPOS_LSB +: 2]  = cfg_q.trigPos;
				dat_d[cfg_query_pkg::MISC_TRQ_LSB +: 2]   = cfg_q.torqueSrc;
				dat_d[cfg_query_pkg::MISC_STANDBY_POWER_QUERY_LSB +: 3]  = cfg_q.stbyLevel;
			end
			cfg_query_pkg::OFF_CHAN: begin
				dat_d[cfg_query_pkg::CHAN_GRP_LSB +: 8]    = cfg_q.chanGroup;
				dat_d[cfg_query_pkg::CHAN_SCALED_LSB +: 4] = cfg_q.chanScaled;
			end
			cfg_query_pkg::OFF_WIRING: dat_d[8:0] = cfg_q.wiring;
			default: begin
				if (adr_i >= cfg_query_pkg::OFF_RESP0 && adr_i <= cfg_query_pkg::OFF_RESP4
					&& adr_i[1:0] == 2'h0) begin
					dat_d = respField_q[3'(adr_i[4:2] - 3'h2)];
				end else if (adr_i >= cfg_query_pkg::OFF_VSCALE0 && adr_i <= cfg_query_pkg::OFF_VSCALE3) begin
					dat_d = cfg_q.voltage_scale_query[adr_i[3:2]];
				end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_TIME0
					&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_TIME2) begin
					dat_d = cfg_q.stbyTime[adr_i[3:2]];
				end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_START0
					&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_START2) begin
					dat_d = cfg_q.stbyStart[adr_i[3:2]];
				end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_END0
					&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_END2) begin
					dat_d = cfg_q.stbyEnd[adr_i[3:2]];
				end
			end
		endcase
	end

	// Live configuration: software writes and snapshot restore
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg_q <= cfg_query_pkg::CFG_RESET;
		end else if (restoreFire && snapValid_q) begin
			cfg_q <= snap_q;
		end else if (wrEn) begin
			unique case (adr_i)
				cfg_query_pkg::OFF_SPD_SCALE:  cfg_q.speedScale   <= mergeBytes(cfg_q.speedScale, dat_i, sel_i);
				cfg_query_pkg::OFF_TRQ_OFFSET: cfg_q.torqueOffset <= mergeBytes(cfg_q.torqueOffset, dat_i, sel_i);
				cfg_query_pkg::OFF_TRQ_SCALE:  cfg_q.torqueScale  <= mergeBytes(cfg_q.torqueScale, dat_i, sel_i);
				cfg_query_pkg::OFF_TRIG_LEVEL: cfg_q.trigLevel    <= mergeBytes(cfg_q.trigLevel, dat_i, sel_i);
				cfg_query_pkg::OFF_MISC: begin
					if (dat_i[cfg_query_pkg::MISC_TB_LSB +: 5] <= cfg_query_pkg::TIMEBASE_MAX) begin
						cfg_q.timebase <= dat_i[cfg_query_pkg::MISC_TB_LSB +: 5];
					end
					cfg_q.trigInput  <= dat_i[cfg_query_pkg::MISC_TIN_LSB +: 3];
					cfg_q.trigMethod <= dat_i[cfg_query_pkg::MISC_TMETH_LSB +: 2];
					cfg_q.trigPos    <= dat_i[cfg_query_pkg::MISC_TPOS_LSB +: 2];
					if (dat_i[cfg_query_pkg::MISC_TRQ_LSB +: 2] <= cfg_query_pkg::TORQUE_MAX) begin
						cfg_q.torqueSrc <= dat_i[cfg_query_pkg::MISC_TRQ_LSB +: 2];
					end
					cfg_q.stbyLevel <= dat_i[cfg_query_pkg::MISC_STANDBY_POWER_QUERY_LSB +: 3];
				end
				cfg_query_pkg::OFF_CHAN: begin
					for (int c = 0; c < 4; c++) begin
						cfg_q.chanGroup[c] <= dat_i[cfg_query_pkg::CHAN_GRP_LSB + 2*c +: 2];
					end
					cfg_q.chanScaled <= dat_i[cfg_query_pkg::CHAN_SCALED_LSB +: 4];
				end
				cfg_query_pkg::OFF_WIRING: begin
					for (int g = 0; g < 3; g++) begin
						if (dat_i[3*g +: 3] <= cfg_query_pkg::WIRING_MAX) begin
							cfg_q.wiring[g] <= dat_i[3*g +: 3];
						end
					end
				end
				default: begin
					if (adr_i >= cfg_query_pkg::OFF_VSCALE0 && adr_i <= cfg_query_pkg::OFF_VSCALE3) begin
						cfg_q.voltage_scale_query[adr_i[3:2]] <= mergeBytes(cfg_q.voltage_scale_query[adr_i[3:2]], dat_i, sel_i);
					end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_TIME0
						&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_TIME2) begin
						cfg_q.stbyTime[adr_i[3:2]] <= mergeBytes(cfg_q.stbyTime[adr_i[3:2]], dat_i, sel_i);
					end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_START0
						&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_START2) begin
						cfg_q.stbyStart[adr_i[3:2]] <= mergeBytes(cfg_q.stbyStart[adr_i[3:2]], dat_i, sel_i);
					end else if (adr_i >= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_END0
						&& adr_i <= cfg_query_pkg::OFF_STANDBY_POWER_QUERY_END2) begin
						cfg_q.stbyEnd[adr_i[3:2]] <= mergeBytes(cfg_q.stbyEnd[adr_i[3:2]], dat_i, sel_i);
					end
				end
			endcase
		end
	end

	// Volatile snapshot store
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			snap_q      <= cfg_query_pkg::CFG_RESET;
			snapValid_q <= 1'b0;
		end else if (storeFire) begin
			snap_q      <= cfg_q;
			snapValid_q <= 1'b1;
		end else if (restoreFire) begin
			snapValid_q <= 1'b0;
		end
	end

	// Command error flag, set wins over write-one clear
	always_comb begin
		cmdBad = 1'b0;
		if (cmdFire) begin
			unique case (cmdOp)
				cfg_query_pkg::OP_SNAP_RESTORE: cmdBad = !snapValid_q;
				cfg_query_pkg::OP_STANDBY, cfg_query_pkg::OP_WIRING:
					cmdBad = !inRange(cmdIdx, cfg_query_pkg::GROUP_COUNT);
				cfg_query_pkg::OP_VOLTAGE_SCALE, cfg_query_pkg::OP_GROUP_MEMBER:
					cmdBad = !inRange(cmdIdx, cfg_query_pkg::CHAN_COUNT);
				default: cmdBad = (cmdOp == 5'h00) || (cmdOp > 5'h0C);
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmdError_q <= 1'b0;
		end else if (cmdBad) begin
			cmdError_q <= 1'b1;
		end else if (wrEn && adr_i == cfg_query_pkg::OFF_STATUS && sel_i[0]
			&& dat_i[cfg_query_pkg::ST_ERROR_BIT]) begin
			cmdError_q <= 1'b0;
		end
	end

	// Query responses
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			respCount_q <= 3'h0;
			respStr_q   <= 8'h00;
			for (int i = 0; i < cfg_query_pkg::RESP_FIELDS; i++) begin
				respField_q[i] <= 32'h00000000;
			end
		end else if (cmdFire && !cmdBad && cmdOp != cfg_query_pkg::OP_SNAP_STORE
			&& cmdOp != cfg_query_pkg::OP_SNAP_RESTORE) begin
			respStr_q   <= 8'h00;
			respCount_q <= cfg_query_pkg::CNT_ONE;
			for (int i = 1; i < cfg_query_pkg::RESP_FIELDS; i++) begin
				respField_q[i] <= 32'h00000000;
			end
			unique case (cmdOp)
				cfg_query_pkg::OP_SPEED_SCALE:   respField_q[0] <= cfg_q.speedScale;
				cfg_query_pkg::OP_TIMEBASE:      respField_q[0] <= 32'(cfg_q.timebase);
				cfg_query_pkg::OP_TORQUE_SRC:    respField_q[0] <= 32'(cfg_q.torqueSrc);
				cfg_query_pkg::OP_TORQUE_OFFSET: respField_q[0] <= cfg_q.torqueOffset;
				cfg_query_pkg::OP_TORQUE_SCALE:  respField_q[0] <= cfg_q.torqueScale;
				cfg_query_pkg::OP_VOLTAGE_SCALE: respField_q[0] <= cfg_q.chanScaled[chSel]
					? cfg_q.voltage_scale_query[chSel] : cfg_query_pkg::REAL_ZERO;
				cfg_query_pkg::OP_GROUP_MEMBER:  respField_q[0] <= 32'(cfg_q.chanGroup[chSel]);
				cfg_query_pkg::OP_WIRING:        respField_q[0] <= 32'(cfg_q.wiring[grpSel]);
				cfg_query_pkg::OP_TRIGGER: begin
					respCount_q    <= cfg_query_pkg::CNT_TRIGGER;
					respField_q[0] <= 32'(cfg_q.trigInput);
					respField_q[1] <= 32'(cfg_q.trigMethod);
					respField_q[2] <= 32'(cfg_q.trigPos);
					respField_q[3] <= cfg_q.trigLevel;
				end
				default: begin
					if (cfg_q.stbyLevel[grpSel]) begin
						respStr_q      <= cfg_query_pkg::STR_LEVEL_METHOD;
						respCount_q    <= cfg_query_pkg::CNT_LEVEL;
						respField_q[0] <= 32'h00000000;
						respField_q[1] <= cfg_q.stbyStart[grpSel];
						respField_q[2] <= cfg_q.stbyEnd[grpSel];
					end else begin
						respStr_q   <= cfg_query_pkg::STR_TIME_METHOD;
						respCount_q <= cfg_query_pkg::CNT_TIME;
						respField_q[0] <= 32'h00000000;
						for (int k = 0; k < 4; k++) begin
							respField_q[k+1] <= 32'(cfg_q.stbyTime[grpSel][k]);
						end
					end
				end
			endcase
		end
	end

	// Checks
	a_restore_no_save: assert property (@(posedge clk_sys) disable iff (!rst_n)
		restoreFire && !snapValid_q |=> cmdError_q && cfg_q == $past(cfg_q))
		else $error("restore without snapshot did not raise error");
	a_restore_loads_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
		restoreFire && snapValid_q |=> cfg_q == $past(snap_q))
		else $error("restore did not load snapshot");
	a_single_restore: assert property (@(posedge clk_sys) disable iff (!rst_n)
		restoreFire && snapValid_q |=> !snapValid_q ##1 !snapValid_q || $past(storeFire))
		else $error("snapshot still valid after restore");
	a_store_copies_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
		storeFire |=> snapValid_q && snap_q == $past(cfg_q))
		else $error("store did not copy configuration");
	a_reset_empty: assert property (@(posedge clk_sys)
		!rst_n |=> !snapValid_q)
		else $error("snapshot valid after reset");
	a_timebase_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg_q.timebase <= cfg_query_pkg::TIMEBASE_MAX)
		else $error("timebase code out of range");
	a_trigger_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && cmdOp == cfg_query_pkg::OP_TRIGGER |=> respCount_q == 3'h4
		&& respField_q[3] == $past(cfg_q.trigLevel) && respField_q[0] == 32'($past(cfg_q.trigInput)))
		else $error("trigger answer malformed");
	a_standby_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && !cmdBad && cmdOp == cfg_query_pkg::OP_STANDBY && !cfg_q.stbyLevel[grpSel]
		|=> respStr_q == 8'h41 && respCount_q == 3'h5)
		else $error("time standby answer malformed");
	a_standby_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && !cmdBad && cmdOp == cfg_query_pkg::OP_STANDBY && cfg_q.stbyLevel[grpSel]
		|=> respStr_q == 8'h44 && respCount_q == 3'h3)
		else $error("level standby answer malformed");
	a_voltage_scale_query_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && !cmdBad && cmdOp == cfg_query_pkg::OP_VOLTAGE_SCALE && !cfg_q.chanScaled[chSel]
		|=> respField_q[0] == 32'h00000000)
		else $error("unscaled channel answered nonzero");
	a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
	a_bad_cmd_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdBad |=> cmdError_q)
		else $error("bad command did not raise error");
	a_bad_keeps_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdBad |=> respCount_q == $past(respCount_q) && respStr_q == $past(respStr_q))
		else $error("bad command changed the answer");
	a_valid_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n)
		restoreFire |=> !snapValid_q)
		else $error("snapshot still valid after restore");
	a_torque_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg_q.torqueSrc <= cfg_query_pkg::TORQUE_MAX)
		else $error("torque source code out of range");
	a_wiring_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cfg_q.wiring[0] <= cfg_query_pkg::WIRING_MAX && cfg_q.wiring[1] <= cfg_query_pkg::WIRING_MAX
		&& cfg_q.wiring[2] <= cfg_query_pkg::WIRING_MAX)
		else $error("wiring code out of range");
	a_speed_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && cmdOp == cfg_query_pkg::OP_SPEED_SCALE |=> respField_q[0] == $past(cfg_q.speedScale))
		else $error("speed scale answer wrong");
	a_timebase_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && cmdOp == cfg_query_pkg::OP_TIMEBASE |=> respField_q[0] == 32'($past(cfg_q.timebase)))
		else $error("timebase answer wrong");
	a_member_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && !cmdBad && cmdOp == cfg_query_pkg::OP_GROUP_MEMBER
		|=> respField_q[0] == 32'($past(cfg_q.chanGroup[chSel])))
		else $error("group membership answer wrong");
	a_ack_follows_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cyc_i && stb_i && !ack_q |=> ack_q)
		else $error("request not acknowledged");
	a_idle_data_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ack_q |-> dat_q == 32'h00000000)
		else $error("read data nonzero without ack");

	c_store_restore: cover property (@(posedge clk_sys) disable iff (!rst_n)
		storeFire ##[1:50] restoreFire && snapValid_q);
	c_double_restore: cover property (@(posedge clk_sys) disable iff (!rst_n)
		restoreFire && snapValid_q ##[1:50] restoreFire);
	c_trigger_query: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && cmdOp == cfg_query_pkg::OP_TRIGGER);
	c_bad_index: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmdBad && cmdOp != cfg_query_pkg::OP_SNAP_RESTORE);
	c_standby_level: cover property (@(posedge clk_sys) disable iff (!rst_n)
		cmdFire && !cmdBad && cmdOp == cfg_query_pkg::OP_STANDBY && cfg_q.stbyLevel[grpSel]);

endmodule

// >>> tb/wb_host_model.sv
// Purpose: Remote host model issuing classic Wishbone transfers
// Assumes: One transfer outstanding, full-word byte enables
// Notes:   Counts acknowledges seen while no request is open
`timescale 1ns/100ps
module wb_host_model (
	input  wire logic        clk_sys,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat,
	input  wire logic [31:0] rdat,
	input  wire logic        ack,
	output int               lost
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end

	// Stray acknowledge
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && cyc !== 1'b1)
			lost++;
	end

	// Request held until ack sampled high, then released
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		dat <= ~d;
	endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the configuration query block
// Assumes: Host model drives the register bus
// Notes:   Random settings from a fixed seed plus corner codes
`timescale 1ns/100ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
	logic        clk_sys;
	logic        rst_n;
	logic        cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, q, v, w, c, m;
	logic [31:0] resp [5];
	logic [4:0]  tbv;
	logic [2:0]  tin, lvl;
	logic [1:0]  tm, tp, trq;
	logic [8:0]  wr3;
	int          errors, numChecks, lost;

	config_query_and_temp_store uut (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack));
	wb_host_model host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat),
		.rdat(rdat), .ack(ack), .lost(lost));

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	function automatic logic [31:0] cw(logic [4:0] op, logic [2:0] idx);
		return {21'h0, idx, 3'h0, op};
	endfunction
	function automatic logic [31:0] miscWord(logic [4:0] t, logic [2:0] i, logic [1:0] me, logic [1:0] p,
		logic [1:0] r, logic [2:0] l);
		return {5'h0, l, 2'h0, r, 2'h0, p, 2'h0, me, 1'h0, i, 3'h0, t};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		host.xfer(1'b1, a, d, t);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		host.xfer(1'b0, a, 32'h0, d);
	endtask
	// Issue a query, check status, gather all response words
	task automatic query(input logic [4:0] op, input logic [2:0] idx, input logic [2:0] cnt, input logic [7:0] s);
		logic [31:0] st;
		wr(cfg_query_pkg::OFF_CMD, cw(op, idx));
		rd(cfg_query_pkg::OFF_STATUS, st);
		`CHK(st[6:4], cnt)
		`CHK(st[1], 1'b0)
		if (op == cfg_query_pkg::OP_STANDBY)
			`CHK(st[15:8], s)
		for (int k = 0; k < 5; k++)
			rd(cfg_query_pkg::OFF_RESP0 + 8'(4 * k), resp[k]);
	endtask
	task automatic conclude();
		errors += lost;
		$display("checks %0d errors %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys);
		errors++;
		conclude();
	end

	initial begin
		rst_n = 1'b0;
		errors = 0;
		numChecks = 0;
		void'($urandom(32'hC4066F54));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h0)
		rd(8'hFC, q);
		`CHK(q, 32'h0)
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_SNAP_RESTORE, 3'h0));
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h2)
		wr(cfg_query_pkg::OFF_STATUS, 32'h2);
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_WIRING, 3'h4));
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h2)
		wr(cfg_query_pkg::OFF_STATUS, 32'h2);
		for (int i = 0; i < 6; i++) begin
			v = $urandom();
			w = $urandom();
			wr(cfg_query_pkg::OFF_SPD_SCALE, v);
			query(cfg_query_pkg::OP_SPEED_SCALE, 3'h0, 3'h1, 8'h00);
			`CHK(resp[0], v)
			wr(cfg_query_pkg::OFF_TRQ_OFFSET, w);
			query(cfg_query_pkg::OP_TORQUE_OFFSET, 3'h0, 3'h1, 8'h00);
			`CHK(resp[0], w)
			wr(cfg_query_pkg::OFF_TRQ_SCALE, ~w);
			query(cfg_query_pkg::OP_TORQUE_SCALE, 3'h0, 3'h1, 8'h00);
			`CHK(resp[0], ~w)
			wr(cfg_query_pkg::OFF_TRIG_LEVEL, v ^ w);
			tbv = (i == 0) ? 5'h00 : (i == 1) ? 5'h14 : 5'($urandom_range(20));
			tin = (i == 1) ? 3'h7 : (i == 0) ? 3'h0 : 3'($urandom_range(7));
			tm = 2'(i);
			tp = ~2'(i);
			trq = 2'(i % 3);
			lvl = 3'($urandom_range(7));
			m = miscWord(tbv, tin, tm, tp, trq, lvl);
			wr(cfg_query_pkg::OFF_MISC, m);
			query(cfg_query_pkg::OP_TIMEBASE, 3'h0, 3'h1, 8'h00);
			`CHK(resp[0], {27'h0, tbv})
			query(cfg_query_pkg::OP_TRIGGER, 3'h0, 3'h4, 8'h00);
			`CHK(resp[0], {29'h0, tin})
			`CHK(resp[1], {30'h0, tm})
			`CHK(resp[2], {30'h0, tp})
			`CHK(resp[3], v ^ w)
			query(cfg_query_pkg::OP_TORQUE_SRC, 3'h0, 3'h1, 8'h00);
			`CHK(resp[0], {30'h0, trq})
			wr(cfg_query_pkg::OFF_MISC, miscWord(5'h15, tin, tm, tp, trq, lvl));
			rd(cfg_query_pkg::OFF_MISC, q);
			`CHK(q[4:0], tbv)
			c = $urandom() & 32'hFFF;
			wr(cfg_query_pkg::OFF_CHAN, c);
			for (int ch = 1; ch <= 4; ch++) begin
				v = $urandom();
				wr(cfg_query_pkg::OFF_VSCALE0 + 8'(4 * (ch - 1)), v);
				query(cfg_query_pkg::OP_VOLTAGE_SCALE, 3'(ch), 3'h1, 8'h00);
				`CHK(resp[0], c[7 + ch] ? v : cfg_query_pkg::REAL_ZERO)
				query(cfg_query_pkg::OP_GROUP_MEMBER, 3'(ch), 3'h1, 8'h00);
				`CHK(resp[0], {30'h0, c[2 * (ch - 1) +: 2]})
			end
			wr3 = {3'($urandom_range(4)), 3'(i % 5), 3'h4 - 3'(i % 5)};
			wr(cfg_query_pkg::OFF_WIRING, {23'h0, wr3});
			for (int g = 1; g <= 3; g++) begin
				v = $urandom();
				w = $urandom();
				c = $urandom();
				query(cfg_query_pkg::OP_WIRING, 3'(g), 3'h1, 8'h00);
				`CHK(resp[0], {29'h0, wr3[3 * (g - 1) +: 3]})
				wr(cfg_query_pkg::OFF_STANDBY_POWER_QUERY_TIME0 + 8'(4 * (g - 1)), v);
				wr(cfg_query_pkg::OFF_STANDBY_POWER_QUERY_START0 + 8'(4 * (g - 1)), w);
				wr(cfg_query_pkg::OFF_STANDBY_POWER_QUERY_END0 + 8'(4 * (g - 1)), c);
				if (lvl[g - 1]) begin
					query(cfg_query_pkg::OP_STANDBY, 3'(g), 3'h3, 8'h44);
					`CHK(resp[1], w)
					`CHK(resp[2], c)
				end else begin
					query(cfg_query_pkg::OP_STANDBY, 3'(g), 3'h5, 8'h41);
					for (int k = 0; k < 4; k++)
						`CHK(resp[k + 1], {24'h0, v[8 * k +: 8]})
				end
			end
		end
		wr(cfg_query_pkg::OFF_SPD_SCALE, 32'h3F800000);
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_SNAP_STORE, 3'h0));
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h1)
		wr(cfg_query_pkg::OFF_SPD_SCALE, 32'h40000000);
		wr(cfg_query_pkg::OFF_MISC, 32'h0);
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_SNAP_RESTORE, 3'h0));
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h0)
		rd(cfg_query_pkg::OFF_SPD_SCALE, q);
		`CHK(q, 32'h3F800000)
		rd(cfg_query_pkg::OFF_MISC, q);
		`CHK(q, m)
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_SNAP_RESTORE, 3'h0));
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h2)
		wr(cfg_query_pkg::OFF_CMD, cw(cfg_query_pkg::OP_SNAP_STORE, 3'h0));
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(cfg_query_pkg::OFF_STATUS, q);
		`CHK(q[1:0], 2'h0)
		conclude();
	end
endmodule
